// >>> hw/qab_out_gen.sv
// Purpose: incremental quadrature AB outputs from demodulated sine and cosine signs
// Assumes: channel samples and oscillator tick synchronous to clock
// Notes: outputs follow an update after two intervals plus the internal time constant
// Functional notes
// - four digital outputs, one symmetric period per electrical period
// - phase B leads phase A by a quarter electrical period
// - quadrants coded A/B as 11, 10, 00, 01, upper bound inclusive
// - each complement output is always the inverse of its phase
// - clockwise motion: B high at every rising edge of A
// - counter-clockwise motion: B low at every rising edge of A
// - one pulse per electrical period; revolution count scales with coil periods
// - integration factor is a setting from 5 through 31
// - output updates once per integration factor plus one oscillator periods
// - latency is two update intervals plus a fixed time constant
// - rate and latency refer to output passing ninety percent after a step
// - all update timing derives from the tank oscillator
// - phase high when its channel is positive, low when negative
// - switching hysteresis about five percent of the opposite channel
`timescale 1ns/10ps
module qab_out_gen (
  // clock and reset
  input wire logic clock,
  input wire logic nrst,
  // oscillator and setting
  input wire logic tank_osc_tick,
  input wire logic [qab_pkg::IF_W-1:0] integ_factor,
  // demodulated channels
  input wire logic signed [qab_pkg::CH_W-1:0] sin_ch,
  input wire logic signed [qab_pkg::CH_W-1:0] cos_ch,
  // quadrature outputs
  output logic phase_a,
  output logic phase_a_n,
  output logic phase_b,
  output logic phase_b_n
);

  localparam int TAU_D = qab_pkg::TAU_CYC;

  qab_pkg::qab_main_t st;
  qab_pkg::qab_main_t next_st;
  logic upd;
  logic [1:0] dec;
  logic [1:0] decisive;
  logic signed [qab_pkg::CH_W-1:0] ch_val [2];
  logic signed [qab_pkg::CH_W-1:0] ch_opp [2];

  // update strobe from tank oscillator periods
  qab_rate_gen u_rate (
    .clock(clock),
    .nrst(nrst),
    .tank_osc_tick(tank_osc_tick),
    .integ_factor(integ_factor),
    .upd(upd)
  );

  // channel routing: index 1 is phase A (sine), index 0 is phase B (cosine)
  assign ch_val[1] = sin_ch;
  assign ch_opp[1] = cos_ch;
  assign ch_val[0] = cos_ch;
  assign ch_opp[0] = sin_ch;

  // per channel sign decision
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_ch
      qab_hyst_cmp u_cmp (
        .val(ch_val[g]),
        .opp(ch_opp[g]),
        .prev(st.pend[g]),
        .dec(dec[g]),
        .decisive(decisive[g])
      );
    end
  endgenerate

  // decision, delay line, output register
  always_comb begin
    next_st = st;
    if (upd) begin
      // A from sine sign, B from cosine sign gives the quadrant code
      next_st.pend = dec;
    end
    // previous interval's decision enters the time constant delay
    next_st.dly[0] = {upd, st.pend};
    for (int i = 1; i < qab_pkg::DLY_N; i++) begin
      next_st.dly[i] = st.dly[i-1];
    end
    if (st.dly[qab_pkg::DLY_N-1][qab_pkg::DLY_V]) begin
      next_st.outq[1] = st.dly[qab_pkg::DLY_N-1][qab_pkg::DLY_A];
      next_st.outq[0] = st.dly[qab_pkg::DLY_N-1][qab_pkg::DLY_B];
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      st.pend <= qab_pkg::RST_PHASE;
      st.dly <= '0;
      st.outq <= qab_pkg::RST_PHASE;
    end else begin
      st <= next_st;
    end
  end

  // phases and complements, one period per electrical period
  assign phase_a = st.outq[1];
  assign phase_b = st.outq[0];
  assign phase_a_n = ~st.outq[1];
  assign phase_b_n = ~st.outq[0];

  property p_cmpl_a;
    @(posedge clock) disable iff (!nrst)
      phase_a_n == !phase_a;
  endproperty
  a_cmpl_a: assert property (p_cmpl_a) else $error("phase a complement wrong");

  property p_cmpl_b;
    @(posedge clock) disable iff (!nrst)
      phase_b_n == !phase_b;
  endproperty
  a_cmpl_b: assert property (p_cmpl_b) else $error("phase b complement wrong");

  property p_sign_a;
    @(posedge clock) disable iff (!nrst)
      upd && decisive[1] |=> st.pend[1] == ($past(sin_ch) > 0);
  endproperty
  a_sign_a: assert property (p_sign_a) else $error("phase a decision not sine sign");

  property p_hold_a;
    @(posedge clock) disable iff (!nrst)
      upd && !decisive[1] |=> $stable(st.pend[1]);
  endproperty
  a_hold_a: assert property (p_hold_a) else $error("phase a moved inside band");

  property p_hold_b;
    @(posedge clock) disable iff (!nrst)
      upd && !decisive[0] |=> $stable(st.pend[0]);
  endproperty
  a_hold_b: assert property (p_hold_b) else $error("phase b moved inside band");

  property p_quad;
    @(posedge clock) disable iff (!nrst)
      upd && (&decisive) |=> st.pend == {$past(sin_ch) > 0, $past(cos_ch) > 0};
  endproperty
  a_quad: assert property (p_quad) else $error("quadrant code wrong");

  sequence s_upd_taken;
    upd ##1 st.dly[0][qab_pkg::DLY_V];
  endsequence

  property p_latency;
    @(posedge clock) disable iff (!nrst)
      upd |-> ##TAU_D ({phase_a, phase_b} == $past(st.pend, TAU_D));
  endproperty
  a_latency: assert property (p_latency) else $error("output delay wrong");

  property p_entry;
    @(posedge clock) disable iff (!nrst)
      s_upd_taken |-> st.dly[0][1:0] == $past(st.pend);
  endproperty
  a_entry: assert property (p_entry) else $error("delay entry wrong");

  property p_only_update;
    @(posedge clock) disable iff (!nrst)
      !$stable({phase_a, phase_b}) |-> $past(upd, TAU_D);
  endproperty
  a_only_update: assert property (p_only_update) else $error("output changed off update");

endmodule

// >>> hw/qab_pkg.sv
// Purpose: shared constants and state types of the quadrature AB output generator
// Assumes: 10 MHz system clock, one tank oscillator tick per oscillator period
// Notes: all timing counts derive from the constants below
package qab_pkg;

  // clock
  localparam int CLK_PERIOD_NS = 100;

  // integration factor limits
  localparam int IF_W = 5;
  localparam logic [IF_W-1:0] IF_MIN = 5'h05;
  localparam logic [IF_W-1:0] IF_MAX = 5'h1F;

  // channel sample width
  localparam int CH_W = 16;

  // hysteresis: 13/256 of the opposite channel magnitude
  localparam int HYST_NUM_W = 8;
  localparam logic [HYST_NUM_W-1:0] HYST_NUM = 8'h0D;
  localparam int HYST_SHIFT = 8;

  // fixed internal time constant
  localparam int TAU_NS = 2200;
  localparam int TAU_CYC = (TAU_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DLY_N = TAU_CYC - 1;

  // delay line entry layout
  localparam int DLY_V = 2;
  localparam int DLY_A = 1;
  localparam int DLY_B = 0;

  // reset values
  localparam logic [1:0] RST_PHASE = 2'h0;
  localparam logic [IF_W-1:0] RST_CNT = 5'h00;

  // rate generator state
  typedef struct packed {
    logic [IF_W-1:0] cnt;
    logic upd;
  } qab_rate_t;

  // main state: decision, delay line, output phases
  typedef struct packed {
    logic [1:0] pend;
    logic [DLY_N-1:0][2:0] dly;
    logic [1:0] outq;
  } qab_main_t;

endpackage

// >>> hw/qab_rate_gen.sv
// Purpose: output update strobe every (integration factor + 1) oscillator periods
// Assumes: tank_osc_tick is a one-cycle pulse per oscillator period
// Notes: integration factor is clamped into its legal range
`timescale 1ns/10ps
module qab_rate_gen (
  // clock and reset
  input wire logic clock,
  input wire logic nrst,
  // oscillator and setting
  input wire logic tank_osc_tick,
  input wire logic [qab_pkg::IF_W-1:0] integ_factor,
  // update strobe
  output logic upd
);

  qab_pkg::qab_rate_t st;
  qab_pkg::qab_rate_t next_st;
  logic [qab_pkg::IF_W-1:0] ifc;

  // clamp setting
  always_comb begin
    if (integ_factor < qab_pkg::IF_MIN) begin
      ifc = qab_pkg::IF_MIN;
    end else begin
      ifc = integ_factor;
    end
  end

  // count oscillator periods
  always_comb begin
    next_st = st;
    next_st.upd = 1'b0;
    if (tank_osc_tick) begin
      if (st.cnt >= ifc) begin
        next_st.cnt = qab_pkg::RST_CNT;
        next_st.upd = 1'b1;
      end else begin
        next_st.cnt = st.cnt + 5'h01;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      st.cnt <= qab_pkg::RST_CNT;
      st.upd <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  assign upd = st.upd;

  property p_if_range;
    @(posedge clock) disable iff (!nrst)
      (ifc >= qab_pkg::IF_MIN) && (ifc <= qab_pkg::IF_MAX);
  endproperty
  a_if_range: assert property (p_if_range) else $error("integration factor out of range");

  property p_upd_cause;
    @(posedge clock) disable iff (!nrst)
      $rose(st.upd) |-> $past(tank_osc_tick) && ($past(st.cnt) >= $past(ifc));
  endproperty
  a_upd_cause: assert property (p_upd_cause) else $error("update without full interval");

  property p_upd_gap;
    @(posedge clock) disable iff (!nrst)
      st.upd |=> !st.upd;
  endproperty
  a_upd_gap: assert property (p_upd_gap) else $error("update strobe too long");

endmodule

// >>> hw/qab_hyst_cmp.sv
// Purpose: sign decision of one channel with hysteresis against the opposite channel
// Assumes: signed two's complement samples
// Notes: purely combinational; holds the previous level inside the band
`timescale 1ns/10ps
module qab_hyst_cmp (
  // samples
  input wire logic signed [qab_pkg::CH_W-1:0] val,
  input wire logic signed [qab_pkg::CH_W-1:0] opp,
  // previous level
  input wire logic prev,
  // decision
  output logic dec,
  output logic decisive
);

  logic [qab_pkg::CH_W:0] mag_val;
  logic [qab_pkg::CH_W:0] mag_opp;
  logic [qab_pkg::CH_W+qab_pkg::HYST_NUM_W:0] prod;
  logic [qab_pkg::CH_W:0] thr;

  always_comb begin
    mag_val = val[qab_pkg::CH_W-1] ? (~{val[qab_pkg::CH_W-1], val} + 1'b1)
                                   : {1'b0, val};
    mag_opp = opp[qab_pkg::CH_W-1] ? (~{opp[qab_pkg::CH_W-1], opp} + 1'b1)
                                   : {1'b0, opp};
    prod = mag_opp * qab_pkg::HYST_NUM;
    thr = prod[qab_pkg::CH_W+qab_pkg::HYST_SHIFT:qab_pkg::HYST_SHIFT];
    // band around zero is relative to the opposite channel
    decisive = (mag_val > thr);
    dec = decisive ? ~val[qab_pkg::CH_W-1] : prev;
  end

endmodule

// >>> testbench/qab_dec_model.sv
// Purpose: far-side quadrature decoder model
// Assumes: phases sampled on the rising clock edge
// Notes: one count step per rising edge of phase a
`timescale 1ns/10ps
module qab_dec_model (
  // clock and reset
  input wire logic clock,
  input wire logic nrst,
  // quadrature inputs
  input wire logic phase_a,
  input wire logic phase_b,
  // position count
  output logic signed [15:0] pos
);
  logic last_a;
  always_ff @(posedge clock) begin
    if (!nrst) begin
      pos <= 16'sh0000;
      last_a <= 1'b0;
    end else begin
      last_a <= phase_a;
      if (phase_a && !last_a) pos <= phase_b ? pos + 16'sh0001 : pos - 16'sh0001;
    end
  end
endmodule

// >>> testbench/quadrature_ab_output_gen_test.sv
// Purpose: self-checking bench of the quadrature ab output generator
// Assumes: inputs driven on the falling edge
// Notes: latency checked as difference between integration factors
`timescale 1ns/10ps
module quadrature_ab_output_gen_test;
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic tank_osc_tick = 1'b0;
  logic [qab_pkg::IF_W-1:0] integ_factor = 5'h05;
  logic signed [qab_pkg::CH_W-1:0] sin_ch = 16'sh0000;
  logic signed [qab_pkg::CH_W-1:0] cos_ch = 16'sh0000;
  logic phase_a, phase_a_n, phase_b, phase_b_n;
  logic signed [15:0] pos;
  int errors = 0;
  int checks = 0;
  int seed = 87876;
  int t5, tx, k;
  logic [4:0] f;

  initial forever #50 clock = ~clock;

  qab_out_gen i_qab_out_gen (.clock(clock), .nrst(nrst), .tank_osc_tick(tank_osc_tick),
    .integ_factor(integ_factor), .sin_ch(sin_ch), .cos_ch(cos_ch), .phase_a(phase_a),
    .phase_a_n(phase_a_n), .phase_b(phase_b), .phase_b_n(phase_b_n));
  qab_dec_model i_qab_dec_model (.clock(clock), .nrst(nrst), .phase_a(phase_a),
    .phase_b(phase_b), .pos(pos));

  task chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task end_sim;
    $display("errors=%0d checks=%0d", errors, checks);
    if (errors == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // expected a/b per quadrant
  function logic [1:0] exp_ab(input int q);
    case (q)
      0: exp_ab = 2'h3;
      1: exp_ab = 2'h2;
      2: exp_ab = 2'h0;
      default: exp_ab = 2'h1;
    endcase
  endfunction

  // channels well outside the hysteresis band
  task set_q(input int q);
    int m1, m2;
    m1 = 1000 + ({$random(seed)} % 15000);
    m2 = 1000 + ({$random(seed)} % 15000);
    sin_ch = (q < 2) ? 16'(m1) : 16'(-m1);
    cos_ch = (q == 0 || q == 3) ? 16'(m2) : 16'(-m2);
  endtask

  task hold(input int n);
    repeat (n) @(negedge clock) tank_osc_tick = ($random(seed) & 3) != 0;
  endtask

  // cycles from reset release to first output change
  task meas(input logic [4:0] v, output int t);
    @(negedge clock);
    nrst = 1'b0;
    integ_factor = v;
    tank_osc_tick = 1'b1;
    sin_ch = 16'sh1000;
    cos_ch = 16'sh1000;
    repeat (16) @(negedge clock);
    chk({14'h0000, phase_a, phase_b}, 16'h0000);
    nrst = 1'b1;
    t = 0;
    while (phase_a !== 1'b1 && t < 300) begin
      @(negedge clock);
      t++;
    end
  endtask

  // complements every cycle
  always @(negedge clock) chk({14'h0000, phase_a_n, phase_b_n}, {14'h0000, ~phase_a, ~phase_b});

  initial begin
    repeat (16) @(negedge clock);
    nrst = 1'b1;
    meas(5'h05, t5);
    meas(5'h02, tx);
    chk(16'(tx), 16'(t5));
    meas(5'h1F, tx);
    chk(16'(tx - t5), 16'h0034);
    f = 5'(6 + ({$random(seed)} % 25));
    meas(f, tx);
    chk(16'(tx - t5), 16'(2 * (f - 5)));
    for (k = 1; k <= 12; k++) begin
      set_q(k % 4);
      hold(168);
      chk({14'h0000, phase_a, phase_b}, {14'h0000, exp_ab(k % 4)});
    end
    chk(pos, 16'h0004);
    for (k = 11; k >= 0; k--) begin
      set_q(k % 4);
      hold(168);
      chk({14'h0000, phase_a, phase_b}, {14'h0000, exp_ab(k % 4)});
    end
    chk(pos, 16'h0001);
    cos_ch = 16'sh3E80;
    sin_ch = -16'sh01F4;
    hold(168);
    chk({15'h0000, phase_a}, 16'h0001);
    sin_ch = -16'sh0384;
    hold(168);
    chk({14'h0000, phase_a, phase_b}, 16'h0001);
    end_sim;
  end

  // hang guard
  initial begin
    #(100 * 20000);
    errors++;
    end_sim;
  end
endmodule
